// [dcb_pkg.sv]
// package: register map, field layout and timing for the config/id bank
package dcb_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CFG2 = 8'h00;
  localparam logic [7:0] OFS_CFG3 = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_ID = 8'h0C;
  localparam logic [7:0] OFS_RCAUSE = 8'h10;
  localparam logic [7:0] OFS_ISTAT = 8'h14;
  localparam logic [7:0] OFS_IMASK = 8'h18;
  localparam logic [7:0] OFS_UNLOCK = 8'h1C;
  // config word 3 fields
  localparam int CFG3_USBPWR = 31;
  localparam int CFG3_USB_IDENT_PIN = 30;
  localparam int CFG3_REMAP1 = 29;
  localparam int CFG3_MOD1 = 28;
  // control register fields
  localparam int CTRL_REMAP_LK = 13;
  localparam int CTRL_MOD_LK = 12;
  localparam int CTRL_JTAG = 3;
  localparam int CTRL_TDO = 0;
  localparam logic [31:0] CTRL_MASK = 32'h0000_3009;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] CFG3_MASK = 32'hF000_FFFF;
  localparam logic [31:0] CFG2_MASK = 32'h0000_0007;
  // reset cause bits
  localparam int RC_BROWNOUT = 1;
  localparam int RC_OVERVOLT = 0;
  // interrupt status bits
  localparam int IRQ_BROWNOUT = 0;
  localparam int IRQ_OVERVOLT = 1;
  localparam int IRQ_LOCKVIOL = 2;
  // unlock keys
  // arbitrary key values
  localparam logic [31:0] KEY1 = 32'h1357_2468;
  localparam logic [31:0] KEY2 = 32'h8642_7531;
  // regulator startup delay
  localparam int STARTUP_NS = 10000;
  localparam int CLK_NS = 8;
  localparam int STARTUP_CYC = (STARTUP_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [2:0] {
    UL_IDLE = 3'b001,
    UL_KEY1 = 3'b010,
    UL_OPEN = 3'b100
  } dcb_ul_t;

  typedef struct packed {
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hsel;
    logic hready;
  } dcb_ahb_req_t;

  typedef struct packed {
    logic [31:0] cfg2;
    logic [31:0] cfg3;
  } dcb_nvm_t;

  typedef struct packed {
    logic usb_power_pin_owner;
    logic usb_ident_pin_owner;
    logic boundary_port_enable;
    logic two_wire_out_use;
    logic pin_remap_wr_ok;
    logic module_disable_wr_ok;
  } dcb_pins_t;
endpackage

// [dcb_bank.sv]
// device configuration and identification register bank with AHB-Lite slave
//
// Design decisions made here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
module dcb_bank
  import dcb_pkg::*;
#(
  parameter logic [3:0] SILICON_REVISION = 4'h1, // arbitrary value
  parameter logic [27:0] PART_IDENTIFIER = 28'h0ABC123, // arbitrary value
  parameter int STARTUP_CYCLES = STARTUP_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // nonvolatile config words, stable at reset release
  input wire logic [31:0] nvm_cfg2_i,
  input wire logic [31:0] nvm_cfg3_i,
  // analog monitors and power events (asynchronous)
  input wire logic overvolt_i,
  input wire logic brownout_i,
  input wire logic wake_i,
  // debug tag read
  output logic [15:0] debug_tag_o,
  // control outputs
  output logic [2:0] sys_pll_in_divider_o,
  output logic [3:0] pll_div_ratio_o,
  output dcb_pins_t pins_o,
  output logic io_enable_o,
  output logic core_reset_o,
  output logic exec_enable_o,
  output logic irq_o
);
  typedef struct packed {
    dcb_nvm_t nvm;
    logic loaded;
    logic [31:0] ctrl;
    logic remap_used;
    logic mod_used;
    dcb_ul_t ul;
    logic [31:0] rcause;
    logic [2:0] istat;
    logic [2:0] imask;
    logic [15:0] startup_cnt;
    logic [1:0] ov_sync;
    logic [1:0] bo_sync;
    logic [1:0] wk_sync;
    logic bo_q;
    logic wk_q;
    logic dph_wr;
    logic [7:0] dph_addr;
    logic [31:0] rdata;
    logic hready;
    logic irq;
    logic core_rst;
    logic exec_en;
    logic io_en;
    logic [3:0] ratio;
    dcb_pins_t pins;
  } dcb_st_t;

  dcb_st_t st_r;
  dcb_st_t st_nxt;

  // divide ratio for the pll input divider code
  function automatic logic [3:0] div_ratio(input logic [2:0] code);
    case (code)
      3'h6: div_ratio = 4'hA;
      3'h7: div_ratio = 4'hC;
      default: div_ratio = {1'b0, code} + 4'h1;
    endcase
  endfunction

  logic aph;
  logic [31:0] cfg3_view;
  logic [31:0] ctrl_wr;
  logic bo_evt;
  logic lock_viol;

  assign aph = hsel_i && hready_i && htrans_i[1];
  assign cfg3_view = st_r.nvm.cfg3 & CFG3_MASK;

  always_comb begin
    st_nxt = st_r;
    lock_viol = 1'b0;
    ctrl_wr = st_r.ctrl;
    // ------------------------------------------------------------------------
    // synchronisers and event detect
    // ------------------------------------------------------------------------
    st_nxt.ov_sync = {st_r.ov_sync[0], overvolt_i};
    st_nxt.bo_sync = {st_r.bo_sync[0], brownout_i};
    st_nxt.wk_sync = {st_r.wk_sync[0], wake_i};
    st_nxt.bo_q = st_r.bo_sync[1];
    st_nxt.wk_q = st_r.wk_sync[1];
    bo_evt = st_r.bo_sync[1] && !st_r.bo_q;
    // ------------------------------------------------------------------------
    // configuration load
    // ------------------------------------------------------------------------
    if (!st_r.loaded) begin
      st_nxt.nvm.cfg2 = nvm_cfg2_i;
      st_nxt.nvm.cfg3 = nvm_cfg3_i;
      st_nxt.loaded = 1'b1;
    end
    // ------------------------------------------------------------------------
    // reset, startup delay
    // ------------------------------------------------------------------------
    st_nxt.io_en = !st_r.ov_sync[1];
    st_nxt.core_rst = st_r.ov_sync[1] || st_r.bo_sync[1];
    if (st_r.ov_sync[1] || st_r.bo_sync[1] || (st_r.wk_sync[1] && !st_r.wk_q)) begin
      st_nxt.startup_cnt = 16'(STARTUP_CYCLES);
    end else if (st_r.startup_cnt != 16'h0000) begin
      st_nxt.startup_cnt = st_r.startup_cnt - 16'h0001;
    end
    st_nxt.exec_en = (st_nxt.startup_cnt == 16'h0000) && !st_nxt.core_rst;
    // ------------------------------------------------------------------------
    // bus
    // ------------------------------------------------------------------------
    st_nxt.hready = 1'b1;
    st_nxt.dph_wr = aph && hwrite_i;
    st_nxt.dph_addr = haddr_i[7:0];
    if (aph && !hwrite_i) begin
      if (haddr_i[7:0] == OFS_CFG2) begin
        st_nxt.rdata = st_r.nvm.cfg2 & CFG2_MASK;
      end else if (haddr_i[7:0] == OFS_CFG3) begin
        st_nxt.rdata = cfg3_view;
      end else if (haddr_i[7:0] == OFS_CTRL) begin
        st_nxt.rdata = st_r.ctrl & CTRL_MASK;
      end else if (haddr_i[7:0] == OFS_ID) begin
        st_nxt.rdata = {SILICON_REVISION, PART_IDENTIFIER};
      end else if (haddr_i[7:0] == OFS_RCAUSE) begin
        st_nxt.rdata = st_r.rcause;
      end else if (haddr_i[7:0] == OFS_ISTAT) begin
        st_nxt.rdata = {29'h0, st_r.istat};
      end else if (haddr_i[7:0] == OFS_IMASK) begin
        st_nxt.rdata = {29'h0, st_r.imask};
      end else begin
        st_nxt.rdata = 32'h0000_0000;
      end
    end
    // data-phase writes
    if (st_r.dph_wr) begin
      if (st_r.dph_addr == OFS_UNLOCK) begin
        if (hwdata_i == KEY1) begin
          st_nxt.ul = UL_KEY1;
        end else if (hwdata_i == KEY2 && st_r.ul == UL_KEY1) begin
          st_nxt.ul = UL_OPEN;
        end else begin
          st_nxt.ul = UL_IDLE;
        end
      end else if (st_r.dph_addr == OFS_CTRL) begin
        ctrl_wr = hwdata_i & CTRL_MASK;
        st_nxt.ctrl[CTRL_JTAG] = ctrl_wr[CTRL_JTAG];
        st_nxt.ctrl[CTRL_TDO] = ctrl_wr[CTRL_TDO];
        if (ctrl_wr[CTRL_REMAP_LK] != st_r.ctrl[CTRL_REMAP_LK]) begin
          // release of the lock is refused once spent in single mode
          if (st_r.ul != UL_OPEN ||
              (!ctrl_wr[CTRL_REMAP_LK] && st_r.remap_used && cfg3_view[CFG3_REMAP1])) begin
            lock_viol = 1'b1;
          end else begin
            st_nxt.ctrl[CTRL_REMAP_LK] = ctrl_wr[CTRL_REMAP_LK];
            if (!ctrl_wr[CTRL_REMAP_LK]) begin
              st_nxt.remap_used = 1'b1;
            end
          end
        end
        if (ctrl_wr[CTRL_MOD_LK] != st_r.ctrl[CTRL_MOD_LK]) begin
          if (st_r.ul != UL_OPEN ||
              (!ctrl_wr[CTRL_MOD_LK] && st_r.mod_used && cfg3_view[CFG3_MOD1])) begin
            lock_viol = 1'b1;
          end else begin
            st_nxt.ctrl[CTRL_MOD_LK] = ctrl_wr[CTRL_MOD_LK];
            if (!ctrl_wr[CTRL_MOD_LK]) begin
              st_nxt.mod_used = 1'b1;
            end
          end
        end
        st_nxt.ul = UL_IDLE;
      end else if (st_r.dph_addr == OFS_RCAUSE) begin
        st_nxt.rcause = st_r.rcause & ~hwdata_i;
      end else if (st_r.dph_addr == OFS_ISTAT) begin
        st_nxt.istat = st_r.istat & ~hwdata_i[2:0];
      end else if (st_r.dph_addr == OFS_IMASK) begin
        st_nxt.imask = hwdata_i[2:0];
      end
    end
    // ------------------------------------------------------------------------
    // sticky events: set wins over clear
    // ------------------------------------------------------------------------
    if (bo_evt) begin
      st_nxt.rcause[RC_BROWNOUT] = 1'b1;
      st_nxt.istat[IRQ_BROWNOUT] = 1'b1;
    end
    if (st_r.ov_sync[1]) begin
      st_nxt.rcause[RC_OVERVOLT] = 1'b1;
      st_nxt.istat[IRQ_OVERVOLT] = 1'b1;
    end
    if (lock_viol) begin
      st_nxt.istat[IRQ_LOCKVIOL] = 1'b1;
    end
    st_nxt.irq = |(st_nxt.istat & st_nxt.imask);
    // ------------------------------------------------------------------------
    // registered pin controls
    // ------------------------------------------------------------------------
    st_nxt.ratio = div_ratio(st_nxt.nvm.cfg2[2:0]);
    st_nxt.pins.usb_power_pin_owner = st_nxt.nvm.cfg3[CFG3_USBPWR];
    st_nxt.pins.usb_ident_pin_owner = st_nxt.nvm.cfg3[CFG3_USB_IDENT_PIN];
    st_nxt.pins.boundary_port_enable = st_nxt.ctrl[CTRL_JTAG];
    st_nxt.pins.two_wire_out_use = st_nxt.ctrl[CTRL_TDO];
    st_nxt.pins.pin_remap_wr_ok = !st_nxt.ctrl[CTRL_REMAP_LK];
    st_nxt.pins.module_disable_wr_ok = !st_nxt.ctrl[CTRL_MOD_LK];
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= '0;
      st_r.ctrl <= CTRL_RST;
      st_r.ul <= UL_IDLE;
      st_r.hready <= 1'b1;
      st_r.io_en <= 1'b1;
      st_r.startup_cnt <= 16'(STARTUP_CYCLES);
      st_r.ratio <= 4'h1;
      st_r.pins.two_wire_out_use <= 1'b1;
      st_r.pins.pin_remap_wr_ok <= 1'b1;
      st_r.pins.module_disable_wr_ok <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------------
  assign hrdata_o = st_r.rdata;
  assign hreadyout_o = st_r.hready;
  assign hresp_o = 1'b0;
  assign debug_tag_o = st_r.nvm.cfg3[15:0];
  assign sys_pll_in_divider_o = st_r.nvm.cfg2[2:0];
  assign pll_div_ratio_o = st_r.ratio;
  assign pins_o = st_r.pins;
  assign io_enable_o = st_r.io_en;
  assign core_reset_o = st_r.core_rst;
  assign exec_enable_o = st_r.exec_en;
  assign irq_o = st_r.irq;

  // ------------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------------
  chk_lock_needs_key: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $rose(st_r.ctrl[CTRL_REMAP_LK]) |-> $past(st_r.ul) == UL_OPEN)
    else $error("remap lock set without unlock");
  chk_modlock_key: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $changed(st_r.ctrl[CTRL_MOD_LK]) |-> $past(st_r.ul) == UL_OPEN)
    else $error("module lock changed without unlock");
  chk_remap_once: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $fell(st_r.ctrl[CTRL_REMAP_LK]) && cfg3_view[CFG3_REMAP1] |-> !$past(st_r.remap_used))
    else $error("second remap release");
  chk_mod_once: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $fell(st_r.ctrl[CTRL_MOD_LK]) && cfg3_view[CFG3_MOD1] |-> !$past(st_r.mod_used))
    else $error("second module release");
  chk_cfg3_zero: assert property (@(posedge clk_i) disable iff (!rstn_i)
    aph && !hwrite_i && haddr_i[7:0] == OFS_CFG3 |=> hrdata_o[27:16] == 12'h000)
    else $error("cfg3 reserved bits nonzero");
  chk_ctrl_zero: assert property (@(posedge clk_i) disable iff (!rstn_i)
    aph && !hwrite_i && haddr_i[7:0] == OFS_CTRL |=> (hrdata_o & ~CTRL_MASK) == 32'h0)
    else $error("ctrl reserved bits nonzero");
  chk_ov_reset: assert property (@(posedge clk_i) disable iff (!rstn_i)
    st_r.ov_sync[1] |=> core_reset_o && !io_enable_o)
    else $error("overvoltage not holding reset");
  chk_bo_flag: assert property (@(posedge clk_i) disable iff (!rstn_i)
    bo_evt |=> st_r.rcause[RC_BROWNOUT] && core_reset_o)
    else $error("brownout flag missing");
  chk_startup_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
    st_r.wk_sync[1] && !st_r.wk_q
    |=> st_r.startup_cnt == 16'(STARTUP_CYCLES) && !exec_enable_o)
    else $error("startup delay not restarted on wake");
  chk_div_map: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sys_pll_in_divider_o == 3'h7 |-> pll_div_ratio_o == 4'hC)
    else $error("divider code 7 wrong");
  chk_div_six: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sys_pll_in_divider_o == 3'h6 |-> pll_div_ratio_o == 4'hA)
    else $error("divider code 6 wrong");
  chk_div_five: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sys_pll_in_divider_o == 3'h5 |-> pll_div_ratio_o == 4'h6)
    else $error("divider code 5 wrong");
  chk_usb_power_owner: assert property (@(posedge clk_i) disable iff (!rstn_i)
    st_r.loaded |-> pins_o.usb_power_pin_owner == cfg3_view[CFG3_USBPWR])
    else $error("usb power pin owner wrong");
  chk_usb_ident_owner: assert property (@(posedge clk_i) disable iff (!rstn_i)
    st_r.loaded |-> pins_o.usb_ident_pin_owner == cfg3_view[CFG3_USB_IDENT_PIN])
    else $error("usb ident pin owner wrong");
  chk_tag_view: assert property (@(posedge clk_i) disable iff (!rstn_i)
    st_r.loaded |-> debug_tag_o == cfg3_view[15:0])
    else $error("debug tag wrong");
  chk_remap_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
    pins_o.pin_remap_wr_ok == !st_r.ctrl[CTRL_REMAP_LK])
    else $error("remap write gate wrong");
  chk_modoff_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
    pins_o.module_disable_wr_ok == !st_r.ctrl[CTRL_MOD_LK])
    else $error("module disable write gate wrong");
  chk_jtag_follow: assert property (@(posedge clk_i) disable iff (!rstn_i)
    pins_o.boundary_port_enable == st_r.ctrl[CTRL_JTAG])
    else $error("boundary port enable wrong");
  chk_tdo_follow: assert property (@(posedge clk_i) disable iff (!rstn_i)
    pins_o.two_wire_out_use == st_r.ctrl[CTRL_TDO])
    else $error("two-wire data-out use wrong");
  chk_id_read: assert property (@(posedge clk_i) disable iff (!rstn_i)
    aph && !hwrite_i && haddr_i[7:0] == OFS_ID
    |=> hrdata_o == {SILICON_REVISION, PART_IDENTIFIER})
    else $error("id register read wrong");
  chk_cfg_frozen: assert property (@(posedge clk_i) disable iff (!rstn_i)
    st_r.loaded && $past(st_r.loaded) |-> $stable(st_r.nvm))
    else $error("config words changed after load");
  chk_bus_okay: assert property (@(posedge clk_i) disable iff (!rstn_i)
    hreadyout_o && !hresp_o)
    else $error("bus not ready or not okay");
  chk_irq_level: assert property (@(posedge clk_i) disable iff (!rstn_i)
    irq_o == |(st_r.istat & st_r.imask))
    else $error("interrupt level wrong");
  chk_viol_flag: assert property (@(posedge clk_i) disable iff (!rstn_i)
    lock_viol |=> st_r.istat[IRQ_LOCKVIOL])
    else $error("lock violation not flagged");
  chk_key_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $fell(st_r.ctrl[CTRL_REMAP_LK]) |-> $past(st_r.ul) == UL_OPEN)
    else $error("remap lock released without unlock");
  chk_key_order: assert property (@(posedge clk_i) disable iff (!rstn_i)
    st_r.ul == UL_OPEN |-> $past(st_r.ul) == UL_KEY1 || $past(st_r.ul) == UL_OPEN)
    else $error("unlock opened out of order");
  chk_bo_sticky: assert property (@(posedge clk_i) disable iff (!rstn_i)
    st_r.rcause[RC_BROWNOUT] && !(st_r.dph_wr && st_r.dph_addr == OFS_RCAUSE)
    |=> st_r.rcause[RC_BROWNOUT])
    else $error("brownout flag lost");
  chk_io_restore: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !st_r.ov_sync[1] |=> io_enable_o)
    else $error("io not enabled without overvoltage");
  chk_exec_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
    core_reset_o |-> !exec_enable_o)
    else $error("execution during core reset");
  cov_unlock: cover property (@(posedge clk_i) disable iff (!rstn_i)
    st_r.ul == UL_KEY1 ##1 st_r.ul == UL_OPEN);
  cov_lock_set: cover property (@(posedge clk_i) disable iff (!rstn_i)
    $rose(st_r.ctrl[CTRL_REMAP_LK]));
  cov_irq: cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(irq_o));
  cov_wake_restart: cover property (@(posedge clk_i) disable iff (!rstn_i)
    st_r.wk_sync[1] && !st_r.wk_q);
  cov_release_refused: cover property (@(posedge clk_i) disable iff (!rstn_i)
    lock_viol && st_r.ul == UL_OPEN);
endmodule

// [dcb_bank_tb_top.sv]
// self-checking testbench for the config/id register bank
`timescale 1ns/1ns
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin errors++; \
  $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module dcb_bank_tb_top;
  import dcb_pkg::*;
  localparam int ST = 8;
  localparam int LIMIT = 30000;
  localparam logic [3:0] REV = 4'h5; // arbitrary value
  localparam logic [27:0] PART = 28'h0246813; // arbitrary value
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'b00;
  logic hwrite_i = 1'b0;
  logic [2:0] hsize_i = 3'b010;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] nvm_cfg2_i = 32'h0;
  logic [31:0] nvm_cfg3_i = 32'h0;
  logic overvolt_i = 1'b0;
  logic brownout_i = 1'b0;
  logic wake_i = 1'b0;
  logic [31:0] hrdata_o;
  logic [31:0] exp_w;
  logic hresp_o;
  logic hreadyout_o;
  logic [15:0] debug_tag_o;
  logic [2:0] sys_pll_in_divider_o;
  logic [3:0] pll_div_ratio_o;
  dcb_pins_t pins_o;
  logic io_enable_o;
  logic core_reset_o;
  logic exec_enable_o;
  logic irq_o;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic rd_pend = 1'b0;
  logic [31:0] exp_q[$];
  logic [3:0] ratio_tab[8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hA, 4'hC};

  always #4 clk_i = ~clk_i;

  dcb_bank #(.SILICON_REVISION(REV), .PART_IDENTIFIER(PART), .STARTUP_CYCLES(ST)) dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hready_i(hreadyout_o),
    .hwdata_i(hwdata_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .nvm_cfg2_i(nvm_cfg2_i), .nvm_cfg3_i(nvm_cfg3_i), .overvolt_i(overvolt_i),
    .brownout_i(brownout_i), .wake_i(wake_i), .debug_tag_o(debug_tag_o),
    .sys_pll_in_divider_o(sys_pll_in_divider_o), .pll_div_ratio_o(pll_div_ratio_o),
    .pins_o(pins_o), .io_enable_o(io_enable_o), .core_reset_o(core_reset_o),
    .exec_enable_o(exec_enable_o), .irq_o(irq_o)
  );

  // ----------------------------------------------------------------------------
  // read monitor: takes the oldest expected word when a read data phase ends
  // ----------------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rd_pend && hreadyout_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("ERROR %0t: read data with no expectation", $time);
      end else begin
        exp_w = exp_q.pop_front();
        `CHK(hrdata_o, exp_w)
        `CHK(hresp_o, 1'b0)
      end
    end
    if (hreadyout_o === 1'b1) begin
      rd_pend <= hsel_i && htrans_i[1] && !hwrite_i;
    end
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    haddr_i <= {24'h000000, a};
    htrans_i <= 2'b10;
    hwrite_i <= wr;
    hsize_i <= 3'b010;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= d;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic unlock();
    bus(1'b1, OFS_UNLOCK, KEY1);
    bus(1'b1, OFS_UNLOCK, KEY2);
  endtask

  task automatic settle();
    repeat (5) @(posedge clk_i);
  endtask

  task automatic do_reset(input logic [31:0] c2, input logic [31:0] c3);
    @(posedge clk_i);
    rstn_i <= 1'b0;
    nvm_cfg2_i <= c2;
    nvm_cfg3_i <= c3;
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    `CHK(exec_enable_o, 1'b0)
    repeat (ST + 2) @(posedge clk_i);
    `CHK(exec_enable_o, 1'b1)
  endtask

  initial begin
    logic [31:0] c2;
    logic [31:0] c3;
    logic [31:0] seed_val;
    seed_val = $urandom(32'h7309E724);
    for (int code = 0; code < 8; code++) begin
      c2 = $urandom();
      c3 = $urandom();
      c2[2:0] = code[2:0];
      c3[29:28] = {2{code[0]}};
      do_reset(c2, c3);
      `CHK(pll_div_ratio_o, ratio_tab[code])
      `CHK(sys_pll_in_divider_o, code[2:0])
      `CHK(pins_o.usb_power_pin_owner, c3[31])
      `CHK(pins_o.usb_ident_pin_owner, c3[30])
      `CHK(debug_tag_o, c3[15:0])
      `CHK(pins_o.boundary_port_enable, 1'b0)
      `CHK(pins_o.two_wire_out_use, 1'b1)
      rd(OFS_CTRL, CTRL_RST);
      bus(1'b1, OFS_CFG2, ~c2);
      bus(1'b1, OFS_CFG3, ~c3);
      bus(1'b1, OFS_ID, 32'hFFFFFFFF);
      rd(OFS_CFG2, c2 & CFG2_MASK);
      rd(OFS_CFG3, c3 & CFG3_MASK);
      rd(OFS_ID, {REV, PART});
      rd(8'h40, 32'h0);
      bus(1'b1, OFS_CTRL, 32'hFFFFFFFF);
      rd(OFS_CTRL, 32'h00000009);
      `CHK(pins_o.boundary_port_enable, 1'b1)
      `CHK(pins_o.pin_remap_wr_ok, 1'b1)
      for (int k = 0; k < 2; k++) begin
        unlock();
        bus(1'b1, OFS_CTRL, 32'h00003009);
        rd(OFS_CTRL, 32'h00003009);
        `CHK(pins_o.pin_remap_wr_ok, 1'b0)
        `CHK(pins_o.module_disable_wr_ok, 1'b0)
        unlock();
        bus(1'b1, OFS_CTRL, 32'h00000009);
      end
      rd(OFS_CTRL, code[0] ? 32'h00003009 : 32'h00000009);
      `CHK(pins_o.module_disable_wr_ok, ~code[0])
    end
    bus(1'b1, OFS_ISTAT, 32'hFFFFFFFF);
    bus(1'b1, OFS_RCAUSE, 32'hFFFFFFFF);
    rd(OFS_ISTAT, 32'h0);
    overvolt_i <= 1'b1;
    settle();
    `CHK(io_enable_o, 1'b0)
    `CHK(core_reset_o, 1'b1)
    overvolt_i <= 1'b0;
    settle();
    `CHK(io_enable_o, 1'b1)
    `CHK(core_reset_o, 1'b0)
    brownout_i <= 1'b1;
    settle();
    brownout_i <= 1'b0;
    settle();
    rd(OFS_RCAUSE, 32'h00000003);
    rd(OFS_ISTAT, 32'h00000003);
    bus(1'b1, OFS_IMASK, 32'h00000001);
    settle();
    `CHK(irq_o, 1'b1)
    bus(1'b1, OFS_ISTAT, 32'h00000001);
    settle();
    `CHK(irq_o, 1'b0)
    bus(1'b1, OFS_CTRL, 32'h00000000);
    rd(OFS_ISTAT, 32'h00000006);
    bus(1'b1, OFS_IMASK, 32'h00000004);
    settle();
    `CHK(irq_o, 1'b1)
    bus(1'b1, OFS_IMASK, 32'h00000000);
    settle();
    `CHK(irq_o, 1'b0)
    bus(1'b1, OFS_RCAUSE, 32'h00000003);
    rd(OFS_RCAUSE, 32'h0);
    wake_i <= 1'b1;
    settle();
    wake_i <= 1'b0;
    `CHK(exec_enable_o, 1'b0)
    repeat (ST + 6) @(posedge clk_i);
    `CHK(exec_enable_o, 1'b1)
    repeat (3) @(posedge clk_i);
    if (exp_q.size() != 0) begin
      errors++;
      $display("ERROR %0t: reads left unanswered", $time);
    end
    report_and_stop();
  end
endmodule
